/* File: common/dde_regs.vh */
// Address map, field positions, reset values and timing counts of the director executor.
// Included by the core file; holds definitions only.
`ifndef DDE_REGS_VH
`define DDE_REGS_VH

// Avalon-MM word offsets (byte address = 4 x index).
`define DDE_REG_CMD        4'h0
`define DDE_REG_DIRECTOR   4'h1
`define DDE_REG_STATUS     4'h2
`define DDE_REG_SEL        4'h3
`define DDE_REG_COUNT      4'h4
`define DDE_REG_CHKWORD    4'h5
`define DDE_REG_FILEWORD   4'h6
`define DDE_REG_FILEADDR   4'h7

// Command codes written to the command register.
`define DDE_OP_DROP_CS     3'h1
`define DDE_OP_STATUS_SEL  3'h2
`define DDE_OP_CORRECT     3'h3
`define DDE_OP_READ        3'h4
`define DDE_OP_END_READ    3'h5

// Director bit positions, numbered from the most significant bit 0 of a 32-bit word.
`define DDE_DIR_BIT(n)     (31 - (n))
`define DDE_BIT_TO_FILE    10
`define DDE_BIT_LEN_SRC    15
`define DDE_BIT_CTL_STS    19

// Status register bit positions (low-order numbering).
`define DDE_ST_BUSY        0
`define DDE_ST_DONE        1
`define DDE_ST_READ        2
`define DDE_ST_TO_FILE     3
`define DDE_ST_CORR_ACT    4
`define DDE_ST_CORRECTABLE 13
`define DDE_ST_UNCORRECT   14

// Reset values.
`define DDE_SEL_RESET      9'h000
`define DDE_COUNT_RESET    16'h0000

// Divider giving the two internal clock phases; disk timing chain length in phases.
`define DDE_PHASE_DIV      4'h3
`define DDE_CHAIN_STEPS    3'h3

`endif

/* File: core/dde_director_exec.v */
// Director executor: runs the drop-control-select, drive-status select,
// error-correction search and normal-read setup directors.
// Assumes an Avalon-MM master on the same clock; drive lines are synchronous to clk_i.
`timescale 1ns/1ns
`include "dde_regs.vh"

module dde_director_exec (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire [3:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output reg  [31:0] avs_readdata_o,
  output reg         avs_waitrequest_o,
  input  wire        drv_sector_mark_i,
  input  wire        drv_index_mark_i,
  input  wire        drv_end_cyl_i,
  output reg         control_select_line_o,
  output reg         control_select_enable_o,
  output reg         disk_function_enable_ff_o,
  output reg         control_tag_enable_o,
  output reg  [8:0]  status_select_o,
  output reg         read_control_ff_o,
  output reg         sector_mark_o,
  output reg         index_mark_o,
  output reg         end_cyl_o,
  output reg         director_done_o,
  output reg         read_in_progress_o,
  output reg         read_to_file_o,
  output reg         byte_control_toggle_o,
  output reg         file_write_upper_o,
  output reg         file_write_lower_o,
  output reg         load_buffer_en_o,
  output reg         read_done_en_o,
  output reg         checkword_en_o,
  output reg         length_check_en_o,
  output reg  [3:0]  file_address_o
);

  localparam [5:0] ST_IDLE  = 6'h01;
  localparam [5:0] ST_DROP  = 6'h02;
  localparam [5:0] ST_STAT  = 6'h04;
  localparam [5:0] ST_CORR  = 6'h08;
  localparam [5:0] ST_READ  = 6'h10;
  localparam [5:0] ST_DONE  = 6'h20;

  // Extracts a director bit given its high-order-first number.
  function dir_bit;
    input [31:0] w;
    input integer n;
    begin
      dir_bit = w[31 - n];
    end
  endfunction

  reg [5:0]  state_r;
  reg [31:0] director_r;
  reg [31:0] checkword_r;
  reg [15:0] file_word_r;
  reg [15:0] count_r;
  reg [3:0]  div_r;
  reg        ph1_r;
  reg        ph2_r;
  reg [2:0]  chain_r;
  reg        chain_run_r;
  reg        disable_cs_r;
  reg        corr_r;
  reg        resync_r;
  reg        correctable_r;
  reg        uncorrectable_r;
  reg        load_from_file_r;
  reg        exec_r;

  wire        bus_wr    = avs_write_i & ~avs_waitrequest_o;
  wire        rd_seen   = avs_read_i & avs_waitrequest_o;
  wire        cmd_wr    = bus_wr & (avs_address_i == `DDE_REG_CMD);
  wire [2:0]  cmd_op    = avs_writedata_i[2:0];
  wire        start_ok  = cmd_wr & (state_r == ST_IDLE);
  wire        count_zero = (count_r == 16'hFFFF);
  wire        chk_zero  = (checkword_r[20:0] == 21'h000000);
  wire [8:0]  sel_field = director_r[`DDE_DIR_BIT(11):`DDE_DIR_BIT(19)];

  // Single-cycle request acceptance: waitrequest drops low for one cycle per access.
  // Read data is registered when the request is first seen, so it stands while waitrequest is low.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h00000000;
    end else begin
      avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
      if (rd_seen) begin
        case (avs_address_i)
          `DDE_REG_DIRECTOR: avs_readdata_o <= director_r;
          `DDE_REG_STATUS: begin
            avs_readdata_o <= 32'h00000000;
            avs_readdata_o[`DDE_ST_BUSY]        <= (state_r != ST_IDLE);
            avs_readdata_o[`DDE_ST_DONE]        <= director_done_o;
            avs_readdata_o[`DDE_ST_READ]        <= read_in_progress_o;
            avs_readdata_o[`DDE_ST_TO_FILE]     <= read_to_file_o;
            avs_readdata_o[`DDE_ST_CORR_ACT]    <= corr_r;
            avs_readdata_o[`DDE_ST_CORRECTABLE] <= correctable_r;
            avs_readdata_o[`DDE_ST_UNCORRECT]   <= uncorrectable_r;
          end
          `DDE_REG_SEL:      avs_readdata_o <= {22'h000000, read_control_ff_o, status_select_o};
          `DDE_REG_COUNT:    avs_readdata_o <= {16'h0000, count_r};
          `DDE_REG_CHKWORD:  avs_readdata_o <= checkword_r;
          `DDE_REG_FILEWORD: avs_readdata_o <= {16'h0000, file_word_r};
          `DDE_REG_FILEADDR: avs_readdata_o <= {28'h0000000, file_address_o};
          default:           avs_readdata_o <= 32'h00000000;
        endcase
      end
    end
  end

  // Two-phase internal clock as enable pulses.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_r <= 4'h0;
      ph1_r <= 1'b0;
      ph2_r <= 1'b0;
    end else begin
      div_r <= (div_r == `DDE_PHASE_DIV) ? 4'h0 : div_r + 4'h1;
      ph1_r <= (div_r == 4'h0);
      ph2_r <= (div_r == 4'h2);
    end
  end

  // Software-loaded director word and file word; the checkword is loaded in the sequencer.
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_lane
      always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          director_r[8*g+7:8*g] <= 8'h00;
        end else if (bus_wr && avs_address_i == `DDE_REG_DIRECTOR
                     && avs_byteenable_i[g] && state_r == ST_IDLE) begin
          director_r[8*g+7:8*g] <= avs_writedata_i[8*g+7:8*g];
        end
      end
    end
  endgenerate

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      file_word_r <= 16'h0000;
    end else if (bus_wr && avs_address_i == `DDE_REG_FILEWORD) begin
      file_word_r <= avs_writedata_i[15:0];
    end
  end

  // Director sequencing.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r                   <= ST_IDLE;
      checkword_r               <= 32'h00000000;
      count_r                   <= `DDE_COUNT_RESET;
      chain_r                   <= 3'h0;
      chain_run_r               <= 1'b0;
      disable_cs_r              <= 1'b0;
      corr_r                    <= 1'b0;
      resync_r                  <= 1'b0;
      correctable_r             <= 1'b0;
      uncorrectable_r           <= 1'b0;
      load_from_file_r          <= 1'b0;
      exec_r                    <= 1'b0;
      director_done_o           <= 1'b0;
      control_select_line_o     <= 1'b0;
      control_select_enable_o   <= 1'b0;
      disk_function_enable_ff_o <= 1'b0;
      control_tag_enable_o      <= 1'b0;
      status_select_o           <= `DDE_SEL_RESET;
      read_control_ff_o         <= 1'b0;
      read_in_progress_o        <= 1'b0;
      read_to_file_o            <= 1'b0;
      byte_control_toggle_o     <= 1'b0;
      file_write_upper_o        <= 1'b0;
      file_write_lower_o        <= 1'b0;
      load_buffer_en_o          <= 1'b0;
      read_done_en_o            <= 1'b0;
      checkword_en_o            <= 1'b0;
      length_check_en_o         <= 1'b0;
      file_address_o            <= 4'h0;
    end else begin
      director_done_o <= 1'b0;
      exec_r          <= 1'b0;
      if (bus_wr && avs_address_i == `DDE_REG_CHKWORD && state_r == ST_IDLE) begin
        checkword_r <= avs_writedata_i;
      end
      if (disable_cs_r) begin
        disk_function_enable_ff_o <= 1'b0;
        control_tag_enable_o      <= 1'b0;
      end
      case (state_r)
        ST_IDLE: begin
          if (start_ok) begin
            case (cmd_op)
              `DDE_OP_DROP_CS: begin
                disable_cs_r          <= 1'b1;
                chain_run_r           <= 1'b1;
                chain_r               <= 3'h0;
                control_select_line_o <= 1'b0;
                state_r               <= ST_DROP;
              end
              `DDE_OP_STATUS_SEL: begin
                state_r <= ST_STAT;
              end
              `DDE_OP_CORRECT: begin
                corr_r          <= 1'b1;
                correctable_r   <= 1'b0;
                uncorrectable_r <= 1'b0;
                resync_r        <= 1'b0;
                count_r         <= ~director_r[15:0];
                state_r         <= ST_CORR;
              end
              `DDE_OP_READ: begin
                exec_r <= 1'b1;
                if (dir_bit(director_r, `DDE_BIT_TO_FILE)) begin
                  file_address_o <= 4'h0;
                end
                if (dir_bit(director_r, `DDE_BIT_LEN_SRC)) begin
                  file_address_o   <= director_r[3:0];
                  load_from_file_r <= 1'b1;
                end else begin
                  count_r <= director_r[15:0];
                end
                read_in_progress_o    <= 1'b1;
                length_check_en_o     <= 1'b1;
                checkword_en_o        <= 1'b1;
                byte_control_toggle_o <= 1'b1;
                load_buffer_en_o      <= 1'b1;
                read_done_en_o        <= 1'b1;
                read_to_file_o     <= dir_bit(director_r, `DDE_BIT_TO_FILE);
                file_write_upper_o <= dir_bit(director_r, `DDE_BIT_TO_FILE);
                file_write_lower_o <= dir_bit(director_r, `DDE_BIT_TO_FILE);
                state_r <= ST_READ;
              end
              `DDE_OP_END_READ: begin
                read_in_progress_o    <= 1'b0;
                length_check_en_o     <= 1'b0;
                checkword_en_o        <= 1'b0;
                byte_control_toggle_o <= 1'b0;
                load_buffer_en_o      <= 1'b0;
                read_done_en_o        <= 1'b0;
                read_to_file_o        <= 1'b0;
                file_write_upper_o    <= 1'b0;
                file_write_lower_o    <= 1'b0;
                state_r               <= ST_DONE;
              end
              default: begin
                state_r <= ST_IDLE;
              end
            endcase
          end
        end
        ST_DROP: begin
          if (ph1_r) begin
            chain_r <= chain_r + 3'h1;
            if (chain_r == 3'h0) begin
              control_select_enable_o <= 1'b0;
            end
            if (chain_r == `DDE_CHAIN_STEPS - 3'h1) begin
              disable_cs_r <= 1'b0;
              chain_run_r  <= 1'b0;
              state_r      <= ST_DONE;
            end
          end
        end
        ST_STAT: begin
          status_select_o   <= sel_field;
          read_control_ff_o <= dir_bit(director_r, `DDE_BIT_CTL_STS);
          state_r           <= ST_DONE;
        end
        ST_CORR: begin
          if (ph2_r && !resync_r) begin
            resync_r <= 1'b1;
          end else if (ph2_r && resync_r) begin
            if (chk_zero) begin
              correctable_r <= 1'b1;
            end
            if (count_zero && !chk_zero) begin
              uncorrectable_r <= 1'b1;
            end
            if (chk_zero || count_zero) begin
              corr_r   <= 1'b0;
              resync_r <= 1'b0;
              state_r  <= ST_DONE;
            end else begin
              checkword_r <= {checkword_r[0], checkword_r[31:1]};
              count_r     <= count_r + 16'h0001;
            end
          end
        end
        ST_READ: begin
          if (load_from_file_r && !exec_r) begin
            count_r          <= ~file_word_r;
            load_from_file_r <= 1'b0;
            state_r          <= ST_DONE;
          end else if (!load_from_file_r) begin
            state_r <= ST_DONE;
          end
        end
        ST_DONE: begin
          director_done_o <= 1'b1;
          state_r         <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Drive event lines are admitted only while read-control is set.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sector_mark_o <= 1'b0;
      index_mark_o  <= 1'b0;
      end_cyl_o     <= 1'b0;
    end else begin
      sector_mark_o <= drv_sector_mark_i & read_control_ff_o;
      index_mark_o  <= drv_index_mark_i & read_control_ff_o;
      end_cyl_o     <= drv_end_cyl_i & read_control_ff_o;
    end
  end

endmodule

/* File: test/dde_drive_model.sv */
// Drive unit model: raises sector and index events on its own schedule, end-of-cylinder only while status select bit 0 is set.
// Shares the executor clock and sees the status-select lines the executor drives.
`timescale 1ns/1ns
module dde_drive_model (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire [8:0] status_select_i,
  output reg        sector_mark_o,
  output reg        index_mark_o,
  output reg        end_cyl_o
);
  reg [5:0] tick_r;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_r        <= 6'h00;
      sector_mark_o <= 1'b0;
      index_mark_o  <= 1'b0;
      end_cyl_o     <= 1'b0;
    end else begin
      tick_r        <= tick_r + 6'h01;
      sector_mark_o <= (tick_r[2:0] == 3'h7);
      index_mark_o  <= (tick_r == 6'h3F);
      end_cyl_o     <= tick_r[5] & status_select_i[0];
    end
  end
endmodule

/* File: test/dde_exec_properties.sv */
// Port-level checker for the director executor.
// Bound to every instance of dde_director_exec; one clock domain.
`timescale 1ns/1ns
module dde_exec_properties (
  input wire       clk_i,
  input wire       rst_i,
  input wire       avs_read_i,
  input wire       avs_write_i,
  input wire       avs_waitrequest_o,
  input wire       drv_sector_mark_i,
  input wire       sector_mark_o,
  input wire       read_control_ff_o,
  input wire [8:0] status_select_o,
  input wire       control_select_line_o,
  input wire       control_select_enable_o,
  input wire       director_done_o,
  input wire       read_in_progress_o,
  input wire       length_check_en_o,
  input wire       checkword_en_o,
  input wire       byte_control_toggle_o,
  input wire       load_buffer_en_o,
  input wire       read_done_en_o,
  input wire       read_to_file_o,
  input wire       file_write_upper_o,
  input wire       file_write_lower_o
);
  wire read_all = &{length_check_en_o, checkword_en_o, byte_control_toggle_o,
                    load_buffer_en_o, read_done_en_o};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_rise_s;
    $rose(avs_read_i || avs_write_i);
  endsequence
  sequence answer_s;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  bus_answer_a: assert property (req_rise_s |=> answer_s)
    else $error("bus answer out of step");
  done_pulse_a: assert property (director_done_o |=> !director_done_o)
    else $error("director done wider than one cycle");
  mark_gate_a: assert property (sector_mark_o == $past(drv_sector_mark_i & read_control_ff_o))
    else $error("sector mark not gated by read control");
  ctl_follow_a: assert property (read_control_ff_o == status_select_o[0])
    else $error("read control differs from control select bit");
  sel_load_a: assert property ($changed(status_select_o) |-> ##[0:2] director_done_o)
    else $error("status select changed outside a director");
  cs_line_a: assert property (!$rose(control_select_line_o))
    else $error("control select line rose");
  cs_enable_a: assert property (!$rose(control_select_enable_o))
    else $error("control select enable rose");
  read_group_a: assert property (read_all == read_in_progress_o)
    else $error("read enables differ from read in progress");
  file_we_a: assert property ({file_write_upper_o, file_write_lower_o} == {2{read_to_file_o}})
    else $error("file write enables differ from read to file");
  read_done_a: assert property ($rose(read_in_progress_o) |-> ##[2:3] director_done_o)
    else $error("read setup did not finish");
endmodule
bind dde_director_exec dde_exec_properties i_dde_exec_properties (.clk_i, .rst_i, .avs_read_i,
  .avs_write_i, .avs_waitrequest_o, .drv_sector_mark_i, .sector_mark_o, .read_control_ff_o,
  .status_select_o, .control_select_line_o, .control_select_enable_o, .director_done_o,
  .read_in_progress_o, .length_check_en_o, .checkword_en_o, .byte_control_toggle_o,
  .load_buffer_en_o, .read_done_en_o, .read_to_file_o, .file_write_upper_o, .file_write_lower_o);

/* File: test/dde_director_exec_tb.sv */
// Self-checking bench for the director executor with a drive unit model.
// Registers are reached over Avalon-MM; the byte enables are tied to full words.
`timescale 1ns/1ns
`include "dde_regs.vh"
module dde_director_exec_tb;
  reg         clk_i = 1'b0;
  reg         rst_i = 1'b1;
  reg  [3:0]  avs_address_i = 4'h0;
  reg         avs_read_i = 1'b0;
  reg         avs_write_i = 1'b0;
  reg  [31:0] avs_writedata_i = 32'h00000000;
  wire [31:0] avs_readdata_o;
  wire        avs_waitrequest_o, sec_w, idx_w, eoc_w, cs_line, cs_en, dfe, cte, rctl, sec_o;
  wire        done, read_in_progress, rtf, tog, wup, wlo, lbuf, rden, cwen, lcen, idx_o, eoc_o;
  wire [8:0]  sel;
  wire [3:0]  faddr;
  reg  [31:0] rd;
  integer     failures = 0;
  integer     comparisons = 0;
  integer     i;
  always #4 clk_i = ~clk_i;
  dde_director_exec i_dde_director_exec (.clk_i(clk_i), .rst_i(rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .drv_sector_mark_i(sec_w), .drv_index_mark_i(idx_w),
    .drv_end_cyl_i(eoc_w), .control_select_line_o(cs_line), .control_select_enable_o(cs_en),
    .disk_function_enable_ff_o(dfe), .control_tag_enable_o(cte), .status_select_o(sel),
    .read_control_ff_o(rctl), .sector_mark_o(sec_o), .index_mark_o(idx_o), .end_cyl_o(eoc_o),
    .director_done_o(done), .read_in_progress_o(read_in_progress), .read_to_file_o(rtf),
    .byte_control_toggle_o(tog), .file_write_upper_o(wup), .file_write_lower_o(wlo),
    .load_buffer_en_o(lbuf), .read_done_en_o(rden), .checkword_en_o(cwen),
    .length_check_en_o(lcen), .file_address_o(faddr));
  dde_drive_model i_dde_drive_model (.clk_i(clk_i), .rst_i(rst_i), .status_select_i(sel),
    .sector_mark_o(sec_w), .index_mark_o(idx_w), .end_cyl_o(eoc_w));
  task close_out;
    begin
      $display("failures %0d comparisons %0d", failures, comparisons);
      if (failures == 0 && comparisons > 0) begin
        $display("verification passed");
      end else begin
        $display("verification failed");
      end
      $finish;
    end
  endtask
  task hang;
    begin
      failures = failures + 1;
      $display("mismatch at %0t: wait ran out", $time);
      close_out;
    end
  endtask
  task check(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task bus(input rnw, input [3:0] a, input [31:0] d);
    integer n;
    begin
      n = 0;
      @(posedge clk_i);
      avs_address_i <= a;
      avs_read_i <= rnw;
      avs_write_i <= !rnw;
      avs_writedata_i <= d;
      @(posedge clk_i);
      while (avs_waitrequest_o !== 1'b0 && n < 50) begin
        @(posedge clk_i);
        n = n + 1;
      end
      if (n >= 50) hang;
      rd = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
    end
  endtask
  task run_cmd(input [2:0] op, input integer bound);
    integer n;
    begin
      n = 0;
      bus(1'b0, `DDE_REG_CMD, {29'h0, op});
      @(negedge clk_i);
      while (done !== 1'b1 && n < bound) begin
        @(negedge clk_i);
        n = n + 1;
      end
      if (n >= bound) hang;
    end
  endtask
  task t_reset;
    begin
      check({avs_waitrequest_o, sel, read_in_progress, rtf, cs_line, cs_en, done}, 32'h00004000);
      bus(1'b1, `DDE_REG_STATUS, 32'h0);
      check(rd, 32'h00000000);
      bus(1'b1, 4'hF, 32'h0);
      check(rd, 32'h00000000);
      $display("test reset done");
    end
  endtask
  task t_status(input [8:0] p);
    integer n;
    begin
      n = 0;
      bus(1'b0, `DDE_REG_DIRECTOR, {11'h0, p, 12'h0});
      run_cmd(`DDE_OP_STATUS_SEL, 20);
      check(sel, p);
      check(rctl, p[0]);
      bus(1'b1, `DDE_REG_SEL, 32'h0);
      check(rd[9:0], {p[0], p});
      while (sec_w !== 1'b1 && n < 20) begin
        @(negedge clk_i);
        n = n + 1;
      end
      if (n >= 20) hang;
      @(negedge clk_i);
      check(sec_o, p[0]);
      $display("test status select done");
    end
  endtask
  task t_drop;
    begin
      bus(1'b0, `DDE_REG_DIRECTOR, 32'h001FF000);
      bus(1'b0, `DDE_REG_CMD, {29'h0, `DDE_OP_DROP_CS});
      run_cmd(`DDE_OP_STATUS_SEL, 60);
      check({dfe, cte}, 2'b00);
      check({cs_line, cs_en}, 2'b00);
      check(sel, 9'h0AA);
      bus(1'b1, `DDE_REG_STATUS, 32'h0);
      check(rd[0], 1'b0);
      $display("test drop select done");
    end
  endtask
  task t_correct(input [20:0] cw, input [15:0] cnt, input [1:0] res, input [15:0] left);
    begin
      bus(1'b0, `DDE_REG_CHKWORD, {11'h0, cw});
      bus(1'b0, `DDE_REG_DIRECTOR, {16'h0, cnt});
      run_cmd(`DDE_OP_CORRECT, 400);
      bus(1'b1, `DDE_REG_STATUS, 32'h0);
      check(rd[14:13], res);
      bus(1'b1, `DDE_REG_COUNT, 32'h0);
      check(rd[15:0], left);
      $display("test correction done");
    end
  endtask
  task t_read(input [31:0] dw, input [3:0] fa, input [15:0] cnt);
    begin
      bus(1'b0, `DDE_REG_FILEWORD, 32'h00001234);
      bus(1'b0, `DDE_REG_DIRECTOR, dw);
      run_cmd(`DDE_OP_READ, 20);
      check(faddr, fa);
      check({read_in_progress, lcen, cwen, tog, lbuf, rden}, 6'h3F);
      check({rtf, wup, wlo}, {3{dw[21]}});
      bus(1'b1, `DDE_REG_COUNT, 32'h0);
      check(rd[15:0], cnt);
      bus(1'b1, `DDE_REG_STATUS, 32'h0);
      check(rd[3:2], {dw[21], 1'b1});
      run_cmd(`DDE_OP_END_READ, 20);
      check(read_in_progress, 1'b0);
      $display("test read done");
    end
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    t_reset;
    t_status(9'h155);
    t_status(9'h0AA);
    t_drop;
    t_correct(21'h000000, 16'h0003, 2'b01, 16'hFFFC);
    t_correct(21'h1FFFFF, 16'h0003, 2'b10, 16'hFFFF);
    t_correct(21'h000000, 16'h0000, 2'b01, 16'hFFFF);
    t_read(32'h0001000A, 4'hA, 16'hEDCB);
    t_read(32'h00200005, 4'h0, 16'h0005);
    close_out;
  end
endmodule
